// ==== inc/otp_host_pkg.sv ====
package otp_host_pkg;

  localparam int CLK_MHZ          = 250;
  localparam int ADDR_W           = 19;
  localparam int CMD_ADDR_W       = 20;
  localparam int DATA_W           = 16;
  localparam int LOW_Q_W          = 15;
  localparam int TMR_W            = 16;
  localparam int PULSE_CNT_W      = 5;

  // Times in ns as printed or chosen
  localparam int PGM_PULSE_NS     = 50000;
  localparam int ADDR_SETTLE_NS   = 200;
  localparam int ACCESS_NS        = 200;
  localparam int SUPPLY_SETTLE_NS = 2000;

  // Fixed pulse width, exact at this rate
  localparam int PGM_PULSE_CYC     = PGM_PULSE_NS * CLK_MHZ / 1000;
  // Least times round up
  localparam int ADDR_SETTLE_CYC   = (ADDR_SETTLE_NS * CLK_MHZ + 999) / 1000;
  localparam int ACCESS_CYC        = (ACCESS_NS * CLK_MHZ + 999) / 1000;
  localparam int SUPPLY_SETTLE_CYC = (SUPPLY_SETTLE_NS * CLK_MHZ + 999) / 1000;

  localparam int SYNC_STAGES      = 2;
  localparam int TMR_LAT          = 2;
  localparam int MAX_PULSES       = 25;
  localparam int PARITY_BIT       = 15;
  localparam int BYTE_W           = 8;

  typedef enum logic [2:0] {
    OP_READ_WORD,
    OP_READ_BYTE,
    OP_IDENTIFY,
    OP_PROGRAM,
    OP_FINAL_VERIFY
  } op_t;

endpackage

// ==== inc/wait_timer_if.sv ====
`timescale 1ns/1ps
`default_nettype none
interface wait_timer_if;
  logic                              start;
  logic [otp_host_pkg::TMR_W-1:0]    load;
  logic                              done;

  modport ctrl (output start, output load, input done);
  modport tmr  (input start, input load, output done);
endinterface : wait_timer_if
`default_nettype wire

// ==== rtl/wait_timer.sv ====
`timescale 1ns/1ps
`default_nettype none
module wait_timer (
  input  wire logic   core_clk,
  input  wire logic   rst_n,
  input  wire logic   clk_en,
  wait_timer_if.tmr   tif
);

  logic [otp_host_pkg::TMR_W-1:0] count_reg;
  logic [otp_host_pkg::TMR_W-1:0] count_next;
  logic                           done_reg;
  logic                           done_next;

  always_comb begin
    count_next = count_reg;
    done_next  = 1'b0;
    if (tif.start) begin
      count_next = tif.load;
    end else if (count_reg != '0) begin
      count_next = count_reg - 1'b1;
      done_next  = (count_reg == otp_host_pkg::TMR_W'(1));
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      count_reg <= '0;
      done_reg  <= 1'b0;
    end else if (clk_en) begin
      count_reg <= count_next;
      done_reg  <= done_next;
    end
  end

  assign tif.done = done_reg;

endmodule // wait_timer
`default_nettype wire

// ==== rtl/otp_host_ctrl.sv ====
// Summary of operation
// - Program data goes out as one full 16-bit word on the data pins.
// - Fast programming: raise program supply and core supply, hold output gate high.
// - Each program pulse is a fixed-width low chip-enable pulse after pins settle.
// - On verify mismatch pulse again, giving up after 25 pulses.
// - The pulse-and-verify loop is run for each address in turn.
// - Final check of contents happens with both supplies back at nominal.
// - With program supply on, chip enable high means no programming.
// - Program verify: gate low, enable high, supply on, compare the word.
// - Identify line at high voltage gives identifier words; select bit picks which.
// - During identify all other address lines are held low.
// - Chip enable selects the device; output gate acts as the read strobe.
`timescale 1ns/1ps
`default_nettype none
module otp_host_ctrl #(
  parameter int PGM_PULSE_CYC = otp_host_pkg::PGM_PULSE_CYC
) (
  input  wire logic                                  core_clk,
  input  wire logic                                  rst_n,
  input  wire logic                                  clk_en,
  input  wire logic                                  cmd_valid,
  input  wire otp_host_pkg::op_t                     cmd_op,
  input  wire logic [otp_host_pkg::CMD_ADDR_W-1:0]   cmd_addr,
  input  wire logic [otp_host_pkg::DATA_W-1:0]       cmd_data,
  output logic                                       cmd_ready,
  output logic                                       rsp_valid,
  output logic [otp_host_pkg::DATA_W-1:0]            rsp_data,
  output logic                                       rsp_fail,
  output logic [otp_host_pkg::PULSE_CNT_W-1:0]       rsp_pulses,
  output logic [otp_host_pkg::ADDR_W-1:0]            rom_addr,
  output logic                                       rom_ce_n,
  output logic                                       rom_oe_n,
  output logic                                       rom_width_sel,
  output logic                                       rom_vpp_en,
  output logic                                       rom_vcc_hi,
  output logic                                       identify_hv_en,
  input  wire logic [otp_host_pkg::LOW_Q_W-1:0]      rom_q_in,
  output logic [otp_host_pkg::LOW_Q_W-1:0]           rom_q_out,
  output logic                                       rom_q_oe,
  input  wire logic                                  top_bit_or_low_addr_in,
  output logic                                       top_bit_or_low_addr_out,
  output logic                                       top_bit_or_low_addr_oe
);

  typedef enum logic [2:0] {
    ST_IDLE, ST_DISPATCH, ST_DROP, ST_READ, ST_SUPPLY, ST_SETUP, ST_PULSE, ST_VERIFY
  } state_t;

  function automatic logic [otp_host_pkg::TMR_W-1:0] tmr_load(input int cyc);
    tmr_load = otp_host_pkg::TMR_W'(cyc - otp_host_pkg::TMR_LAT);
  endfunction

  function automatic logic odd_parity(input logic [otp_host_pkg::DATA_W-1:0] w);
    odd_parity = ^w;
  endfunction

  wait_timer_if tif ();

  wait_timer u_timer (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .clk_en   (clk_en),
    .tif      (tif)
  );

  // Pins are asynchronous to core_clk
  logic [otp_host_pkg::DATA_W-1:0] sync1_reg;
  logic [otp_host_pkg::DATA_W-1:0] sync2_reg;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      sync1_reg <= '0;
      sync2_reg <= '0;
    end else if (clk_en) begin
      sync1_reg <= {top_bit_or_low_addr_in, rom_q_in};
      sync2_reg <= sync1_reg;
    end
  end

  state_t                                    state_reg,   state_next;
  otp_host_pkg::op_t                         op_reg,      op_next;
  logic [otp_host_pkg::CMD_ADDR_W-1:0]       addr_reg,    addr_next;
  logic [otp_host_pkg::DATA_W-1:0]           wdata_reg,   wdata_next;
  logic [otp_host_pkg::PULSE_CNT_W-1:0]      pulses_reg,  pulses_next;
  logic                                      prog_reg,    prog_next;
  logic                                      ready_reg,   ready_next;
  logic                                      rvalid_reg,  rvalid_next;
  logic [otp_host_pkg::DATA_W-1:0]           rdata_reg,   rdata_next;
  logic                                      rfail_reg,   rfail_next;
  logic [otp_host_pkg::PULSE_CNT_W-1:0]      rpulse_reg,  rpulse_next;
  logic [otp_host_pkg::ADDR_W-1:0]           paddr_reg,   paddr_next;
  logic                                      ce_n_reg,    ce_n_next;
  logic                                      oe_n_reg,    oe_n_next;
  logic                                      width_reg,   width_next;
  logic                                      vpp_reg,     vpp_next;
  logic                                      vcc_reg,     vcc_next;
  logic                                      idhv_reg,    idhv_next;
  logic [otp_host_pkg::LOW_Q_W-1:0]          qout_reg,    qout_next;
  logic                                      qoe_reg,     qoe_next;
  logic                                      tout_reg,    tout_next;
  logic                                      toe_reg,     toe_next;
  logic                                      tstart_reg,  tstart_next;
  logic [otp_host_pkg::TMR_W-1:0]            tload_reg,   tload_next;

  assign tif.start = tstart_reg;
  assign tif.load  = tload_reg;

  always_comb begin
    state_next  = state_reg;
    op_next     = op_reg;
    addr_next   = addr_reg;
    wdata_next  = wdata_reg;
    pulses_next = pulses_reg;
    prog_next   = prog_reg;
    ready_next  = ready_reg;
    rvalid_next = 1'b0;
    rdata_next  = rdata_reg;
    rfail_next  = rfail_reg;
    rpulse_next = rpulse_reg;
    paddr_next  = paddr_reg;
    ce_n_next   = ce_n_reg;
    oe_n_next   = oe_n_reg;
    width_next  = width_reg;
    vpp_next    = vpp_reg;
    vcc_next    = vcc_reg;
    idhv_next   = idhv_reg;
    qout_next   = qout_reg;
    qoe_next    = qoe_reg;
    tout_next   = tout_reg;
    toe_next    = toe_reg;
    tstart_next = 1'b0;
    tload_next  = tload_reg;
    unique case (state_reg)
      ST_IDLE: begin
        if (cmd_valid && ready_reg) begin
          op_next    = cmd_op;
          addr_next  = cmd_addr;
          wdata_next = cmd_data;
          ready_next = 1'b0;
          state_next = ST_DISPATCH;
        end
      end
      ST_DISPATCH: begin
        if (op_reg == otp_host_pkg::OP_PROGRAM) begin
          // Supplies stay raised across back-to-back addresses
          paddr_next  = addr_reg[otp_host_pkg::ADDR_W-1:0];
          pulses_next = '0;
          vpp_next    = 1'b1;
          vcc_next    = 1'b1;
          width_next  = 1'b1;
          oe_n_next   = 1'b1;
          ce_n_next   = 1'b1;
          prog_next   = 1'b1;
          tstart_next = 1'b1;
          tload_next  = prog_reg ? tload_next_min() : tmr_load(otp_host_pkg::SUPPLY_SETTLE_CYC);
          state_next  = ST_SUPPLY;
        end else if (prog_reg) begin
          // Reads and final check only at nominal supplies
          vpp_next    = 1'b0;
          vcc_next    = 1'b0;
          prog_next   = 1'b0;
          tstart_next = 1'b1;
          tload_next  = tmr_load(otp_host_pkg::SUPPLY_SETTLE_CYC);
          state_next  = ST_DROP;
        end else begin
          ce_n_next  = 1'b0;
          oe_n_next  = 1'b0;
          width_next = (op_reg != otp_host_pkg::OP_READ_BYTE);
          if (op_reg == otp_host_pkg::OP_READ_BYTE) begin
            paddr_next = addr_reg[otp_host_pkg::CMD_ADDR_W-1:1];
            tout_next  = addr_reg[0];
            toe_next   = 1'b1;
          end else if (op_reg == otp_host_pkg::OP_IDENTIFY) begin
            paddr_next = {{(otp_host_pkg::ADDR_W-1){1'b0}}, addr_reg[0]};
            idhv_next  = 1'b1;
          end else begin
            paddr_next = addr_reg[otp_host_pkg::ADDR_W-1:0];
          end
          tstart_next = 1'b1;
          tload_next  = tmr_load(otp_host_pkg::ACCESS_CYC + otp_host_pkg::SYNC_STAGES);
          state_next  = ST_READ;
        end
      end
      ST_DROP: begin
        if (tif.done) begin
          state_next = ST_DISPATCH;
        end
      end
      ST_READ: begin
        if (tif.done) begin
          ce_n_next   = 1'b1;
          oe_n_next   = 1'b1;
          idhv_next   = 1'b0;
          toe_next    = 1'b0;
          rvalid_next = 1'b1;
          rpulse_next = '0;
          rfail_next  = 1'b0;
          rdata_next  = sync2_reg;
          unique case (op_reg)
            otp_host_pkg::OP_READ_BYTE:
              rdata_next = {{otp_host_pkg::BYTE_W{1'b0}}, sync2_reg[otp_host_pkg::BYTE_W-1:0]};
            otp_host_pkg::OP_IDENTIFY:
              rfail_next = !odd_parity(sync2_reg);
            otp_host_pkg::OP_FINAL_VERIFY:
              rfail_next = (sync2_reg != wdata_reg);
            default:
              rfail_next = 1'b0;
          endcase
          ready_next = 1'b1;
          state_next = ST_IDLE;
        end
      end
      ST_SUPPLY: begin
        if (tif.done) begin
          // Data only once output gate is high and the bus has turned round
          qout_next   = wdata_reg[otp_host_pkg::LOW_Q_W-1:0];
          tout_next   = wdata_reg[otp_host_pkg::PARITY_BIT];
          qoe_next    = 1'b1;
          toe_next    = 1'b1;
          tstart_next = 1'b1;
          tload_next  = tmr_load(otp_host_pkg::ADDR_SETTLE_CYC);
          state_next  = ST_SETUP;
        end
      end
      ST_SETUP: begin
        if (tif.done) begin
          ce_n_next   = 1'b0;
          pulses_next = pulses_reg + 1'b1;
          tstart_next = 1'b1;
          tload_next  = tmr_load(PGM_PULSE_CYC);
          state_next  = ST_PULSE;
        end
      end
      ST_PULSE: begin
        if (tif.done) begin
          // Data held past the enable's rise, where the cell latches it
          ce_n_next   = 1'b1;
          tstart_next = 1'b1;
          tload_next  = tmr_load(otp_host_pkg::ADDR_SETTLE_CYC);
          state_next  = ST_VERIFY;
        end
      end
      ST_VERIFY: begin
        if (tif.done) begin
          if (oe_n_reg) begin
            // Bus released only as the output gate opens
            qoe_next    = 1'b0;
            toe_next    = 1'b0;
            oe_n_next   = 1'b0;
            tstart_next = 1'b1;
            tload_next  = tmr_load(otp_host_pkg::ACCESS_CYC + otp_host_pkg::SYNC_STAGES);
          end else begin
            oe_n_next = 1'b1;
            if (sync2_reg == wdata_reg ||
                pulses_reg == otp_host_pkg::PULSE_CNT_W'(otp_host_pkg::MAX_PULSES)) begin
              rvalid_next = 1'b1;
              rdata_next  = sync2_reg;
              rfail_next  = (sync2_reg != wdata_reg);
              rpulse_next = pulses_reg;
              ready_next  = 1'b1;
              state_next  = ST_IDLE;
            end else begin
              tstart_next = 1'b1;
              tload_next  = tmr_load(otp_host_pkg::ADDR_SETTLE_CYC);
              state_next  = ST_SUPPLY;
            end
          end
        end
      end
    endcase
  end

  // Shortest wait when supplies are already up
  function automatic logic [otp_host_pkg::TMR_W-1:0] tload_next_min();
    tload_next_min = otp_host_pkg::TMR_W'(1);
  endfunction

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg  <= ST_IDLE;
      op_reg     <= otp_host_pkg::OP_READ_WORD;
      addr_reg   <= '0;
      wdata_reg  <= '0;
      pulses_reg <= '0;
      prog_reg   <= 1'b0;
      ready_reg  <= 1'b1;
      rvalid_reg <= 1'b0;
      rdata_reg  <= '0;
      rfail_reg  <= 1'b0;
      rpulse_reg <= '0;
      paddr_reg  <= '0;
      ce_n_reg   <= 1'b1;
      oe_n_reg   <= 1'b1;
      width_reg  <= 1'b1;
      vpp_reg    <= 1'b0;
      vcc_reg    <= 1'b0;
      idhv_reg   <= 1'b0;
      qout_reg   <= '0;
      qoe_reg    <= 1'b0;
      tout_reg   <= 1'b0;
      toe_reg    <= 1'b0;
      tstart_reg <= 1'b0;
      tload_reg  <= '0;
    end else if (clk_en) begin
      state_reg  <= state_next;
      op_reg     <= op_next;
      addr_reg   <= addr_next;
      wdata_reg  <= wdata_next;
      pulses_reg <= pulses_next;
      prog_reg   <= prog_next;
      ready_reg  <= ready_next;
      rvalid_reg <= rvalid_next;
      rdata_reg  <= rdata_next;
      rfail_reg  <= rfail_next;
      rpulse_reg <= rpulse_next;
      paddr_reg  <= paddr_next;
      ce_n_reg   <= ce_n_next;
      oe_n_reg   <= oe_n_next;
      width_reg  <= width_next;
      vpp_reg    <= vpp_next;
      vcc_reg    <= vcc_next;
      idhv_reg   <= idhv_next;
      qout_reg   <= qout_next;
      qoe_reg    <= qoe_next;
      tout_reg   <= tout_next;
      toe_reg    <= toe_next;
      tstart_reg <= tstart_next;
      tload_reg  <= tload_next;
    end
  end

  assign cmd_ready               = ready_reg;
  assign rsp_valid               = rvalid_reg;
  assign rsp_data                = rdata_reg;
  assign rsp_fail                = rfail_reg;
  assign rsp_pulses              = rpulse_reg;
  assign rom_addr                = paddr_reg;
  assign rom_ce_n                = ce_n_reg;
  assign rom_oe_n                = oe_n_reg;
  assign rom_width_sel           = width_reg;
  assign rom_vpp_en              = vpp_reg;
  assign rom_vcc_hi              = vcc_reg;
  assign identify_hv_en          = idhv_reg;
  assign rom_q_out               = qout_reg;
  assign rom_q_oe                = qoe_reg;
  assign top_bit_or_low_addr_out = tout_reg;
  assign top_bit_or_low_addr_oe  = toe_reg;

endmodule // otp_host_ctrl
`default_nettype wire

// ==== tb/otp_rom_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module otp_rom_model #(
  parameter int          AW     = 4,
  parameter logic [15:0] MFR_ID = 16'h0007, // Arbitrary value, odd parity
  parameter logic [15:0] DEV_ID = 16'h8A5F  // Arbitrary value, odd parity
) (
  input  wire logic [18:0] addr,
  input  wire logic        ce_n,
  input  wire logic        oe_n,
  input  wire logic        width_sel,
  input  wire logic        vpp,
  input  wire logic        vcc_hi,
  input  wire logic        id_hv,
  input  wire logic [15:0] q,
  input  wire logic [4:0]  need,
  input  wire logic        id_flip,
  output logic      [15:0] q_o,
  output logic             oe_lo,
  output logic             oe_hi
);
  logic [15:0]   mem [2**AW];
  logic [4:0]    cnt [2**AW];
  logic [AW-1:0] ix;
  logic [15:0]   word;
  logic          rd;
  logic          vfy;
  initial begin
    for (int i = 0; i < 2**AW; i++) begin
      mem[i] = 16'hFFFF;
      cnt[i] = 5'h00;
    end
  end
  assign ix = addr[AW-1:0];
  // A cell takes data only after need pulses, so the host must retry
  always @(posedge ce_n) begin
    if (vpp && vcc_hi && oe_n) begin
      if (cnt[ix] != 5'h1F) cnt[ix] = cnt[ix] + 5'h01;
      if (cnt[ix] >= need) mem[ix] = mem[ix] & q;
    end
  end
  assign rd    = !ce_n && !oe_n;
  assign vfy   = ce_n && !oe_n && vpp;
  assign word  = id_hv ? (addr[0] ? DEV_ID : MFR_ID) ^ {15'h0000, id_flip} : mem[ix];
  assign q_o   = (width_sel || vpp) ? word : {8'h00, q[15] ? word[15:8] : word[7:0]};
  assign oe_lo = rd || vfy;
  assign oe_hi = (rd && width_sel) || vfy;
endmodule // otp_rom_model
`default_nettype wire

// ==== tb/otp_host_ctrl_chk.sv ====
`timescale 1ns/1ps
`default_nettype none
module otp_host_ctrl_chk #(
  parameter int PGM_PULSE_CYC = 20
) (
  input wire logic              core_clk,
  input wire logic              rst_n,
  input wire logic              clk_en,
  input wire logic              cmd_valid,
  input wire otp_host_pkg::op_t cmd_op,
  input wire logic [19:0]       cmd_addr,
  input wire logic              cmd_ready,
  input wire logic              rsp_valid,
  input wire logic [4:0]        rsp_pulses,
  input wire logic [18:0]       rom_addr,
  input wire logic              rom_ce_n,
  input wire logic              rom_oe_n,
  input wire logic              rom_width_sel,
  input wire logic              rom_vpp_en,
  input wire logic              rom_vcc_hi,
  input wire logic              identify_hv_en,
  input wire logic [14:0]       rom_q_out,
  input wire logic              rom_q_oe,
  input wire logic              top_bit_or_low_addr_out,
  input wire logic              top_bit_or_low_addr_oe
);
  logic [15:0] lo_reg, lo_next;
  logic [4:0]  pc_reg, pc_next;
  logic [19:0] cap_reg, cap_next;
  logic        ce_q_reg, take;
  assign take = cmd_valid && cmd_ready && clk_en;
  always_comb begin
    lo_next  = rom_ce_n ? 16'h0000 : lo_reg + {15'h0000, clk_en};
    pc_next  = take ? 5'h00 : pc_reg + {4'h0, rom_ce_n & ~ce_q_reg & rom_vpp_en};
    cap_next = take ? cmd_addr : cap_reg;
  end
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      lo_reg   <= 16'h0000;
      pc_reg   <= 5'h00;
      cap_reg  <= 20'h00000;
      ce_q_reg <= 1'b1;
    end else begin
      lo_reg   <= lo_next;
      pc_reg   <= pc_next;
      cap_reg  <= cap_next;
      ce_q_reg <= rom_ce_n;
    end
  end
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  sequence s_take(o); take && cmd_op == o && !rom_vpp_en; endsequence
  sequence s_word; !rom_ce_n && !rom_oe_n && rom_width_sel && rom_addr == cap_reg[18:0]; endsequence
  sequence s_byte;
    !rom_ce_n && !rom_oe_n && !rom_width_sel && top_bit_or_low_addr_oe &&
    top_bit_or_low_addr_out == cap_reg[0] && rom_addr == cap_reg[19:1];
  endsequence
  sequence s_verify; rom_vpp_en && !rom_oe_n && rom_ce_n && !rom_q_oe; endsequence
  property p_read_word; s_take(otp_host_pkg::OP_READ_WORD) |-> ##[2:3] s_word ##[40:60] rsp_valid; endproperty
  property p_read_byte; s_take(otp_host_pkg::OP_READ_BYTE) |-> ##[2:3] s_byte ##[40:60] rsp_valid; endproperty
  property p_identify; identify_hv_en && !rom_ce_n |-> rom_addr == {18'h00000, cap_reg[0]} && !rom_vpp_en; endproperty
  property p_prog_setup; $fell(rom_ce_n) && rom_vpp_en |-> rom_vcc_hi && rom_oe_n && $past(rom_q_oe, 40); endproperty
  property p_supply_order; rom_vpp_en |-> rom_vcc_hi; endproperty
  property p_pulse_width; $rose(rom_ce_n) && rom_vpp_en |-> lo_reg == PGM_PULSE_CYC; endproperty
  property p_pulse_data;
    !rom_ce_n && rom_vpp_en |-> rom_q_oe && top_bit_or_low_addr_oe && $stable(rom_q_out) && $stable(rom_addr);
  endproperty
  property p_data_hold;
    $rose(rom_ce_n) && rom_vpp_en |-> rom_q_oe && top_bit_or_low_addr_oe && $stable(rom_q_out);
  endproperty
  property p_verify_mode; rom_vpp_en && !rom_oe_n |-> s_verify; endproperty
  property p_pulse_verify; $rose(rom_ce_n) && rom_vpp_en |-> ##[1:120] s_verify; endproperty
  property p_pulse_count; rsp_valid |-> rsp_pulses == pc_reg && pc_reg <= 5'h19; endproperty
  property p_nominal; !rom_ce_n && !rom_oe_n |-> !rom_vpp_en && !rom_vcc_hi; endproperty
  property p_no_contend; rom_q_oe |-> rom_oe_n && rom_width_sel; endproperty
  a_read_word: assert property (p_read_word) else $error("word read pins wrong");
  a_read_byte: assert property (p_read_byte) else $error("byte read pins wrong");
  a_identify: assert property (p_identify) else $error("identify address wrong");
  a_prog_setup: assert property (p_prog_setup) else $error("program setup wrong");
  a_supply_order: assert property (p_supply_order) else $error("supply order wrong");
  a_pulse_width: assert property (p_pulse_width) else $error("pulse width wrong");
  a_pulse_data: assert property (p_pulse_data) else $error("pulse data unstable");
  a_data_hold: assert property (p_data_hold) else $error("data dropped at enable rise");
  a_verify_mode: assert property (p_verify_mode) else $error("verify mode pins wrong");
  a_pulse_verify: assert property (p_pulse_verify) else $error("no verify after pulse");
  a_pulse_count: assert property (p_pulse_count) else $error("pulse count wrong");
  a_nominal: assert property (p_nominal) else $error("read at raised supply");
  a_no_contend: assert property (p_no_contend) else $error("data bus contention");
endmodule // otp_host_ctrl_chk
bind otp_host_ctrl otp_host_ctrl_chk #(.PGM_PULSE_CYC(PGM_PULSE_CYC)) chk_u (
  .core_clk, .rst_n, .clk_en, .cmd_valid, .cmd_op, .cmd_addr, .cmd_ready, .rsp_valid, .rsp_pulses,
  .rom_addr, .rom_ce_n, .rom_oe_n, .rom_width_sel, .rom_vpp_en, .rom_vcc_hi, .identify_hv_en,
  .rom_q_out, .rom_q_oe, .top_bit_or_low_addr_out, .top_bit_or_low_addr_oe);
`default_nettype wire

// ==== tb/otp_rom_mode_control_test.sv ====
`timescale 1ns/1ps
`default_nettype none
module otp_rom_mode_control_test;
  localparam int          PULSE  = 20;
  localparam logic [15:0] MFR_ID = 16'h0007; // Arbitrary value, odd parity
  localparam logic [15:0] DEV_ID = 16'h8A5F; // Arbitrary value, odd parity
  logic              core_clk  = 1'b0;
  logic              rst_n     = 1'b0;
  logic              clk_en    = 1'b1;
  logic              cmd_valid = 1'b0;
  otp_host_pkg::op_t cmd_op    = otp_host_pkg::OP_READ_WORD;
  logic [19:0]       cmd_addr  = 20'h00000;
  logic [15:0]       cmd_data  = 16'h0000;
  logic              flt       = 1'b0;
  logic              id_flip   = 1'b0;
  logic [4:0]        need      = 5'h01;
  logic [15:0]       rsp_data, m_q, bus, d;
  logic [4:0]        rsp_pulses;
  logic [18:0]       rom_addr;
  logic [14:0]       rom_q_out;
  logic              cmd_ready, rsp_valid, rsp_fail, rom_ce_n, rom_oe_n, rom_width_sel, rom_vpp_en;
  logic              rom_vcc_hi, identify_hv_en, rom_q_oe, top_out, top_oe, m_lo, m_hi;
  logic [15:0]       shadow [8];
  int                n_errors = 0;
  int                n_checks = 0;
  int                seed = 32'h232B;
  always #2 core_clk = ~core_clk;
  // Undriven lines have no pull, so they wander every cycle
  always @(posedge core_clk) flt <= ~flt;
  assign bus[7:0]  = rom_q_oe ? rom_q_out[7:0] : m_lo ? m_q[7:0] : {8{flt}};
  assign bus[14:8] = rom_q_oe ? rom_q_out[14:8] : m_hi ? m_q[14:8] : {7{flt}};
  assign bus[15]   = top_oe ? top_out : m_hi ? m_q[15] : flt;
  otp_host_ctrl #(.PGM_PULSE_CYC(PULSE)) dut_u (
    .core_clk, .rst_n, .clk_en, .cmd_valid, .cmd_op, .cmd_addr, .cmd_data, .cmd_ready, .rsp_valid,
    .rsp_data, .rsp_fail, .rsp_pulses, .rom_addr, .rom_ce_n, .rom_oe_n, .rom_width_sel, .rom_vpp_en,
    .rom_vcc_hi, .identify_hv_en, .rom_q_in(bus[14:0]), .rom_q_out, .rom_q_oe,
    .top_bit_or_low_addr_in(bus[15]), .top_bit_or_low_addr_out(top_out), .top_bit_or_low_addr_oe(top_oe));
  otp_rom_model #(.MFR_ID(MFR_ID), .DEV_ID(DEV_ID)) rom_u (
    .addr(rom_addr), .ce_n(rom_ce_n), .oe_n(rom_oe_n), .width_sel(rom_width_sel), .vpp(rom_vpp_en),
    .vcc_hi(rom_vcc_hi), .id_hv(identify_hv_en), .q(bus), .need, .id_flip, .q_o(m_q), .oe_lo(m_lo),
    .oe_hi(m_hi));
  function automatic logic [15:0] byte_of(input logic [15:0] w, input logic s);
    return {8'h00, s ? w[15:8] : w[7:0]};
  endfunction
  task automatic chk(input string name, input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("Error %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic test_done;
    if (n_errors == 0 && n_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic run(input otp_host_pkg::op_t op, input logic [19:0] a, input logic [15:0] dat);
    int i;
    @(negedge core_clk);
    cmd_valid = 1'b1;
    cmd_op    = op;
    cmd_addr  = a;
    cmd_data  = dat;
    @(negedge core_clk);
    cmd_valid = 1'b0;
    i = 0;
    while (rsp_valid !== 1'b1 && i < 20000) begin
      @(negedge core_clk);
      i++;
    end
    if (i == 20000) begin
      n_errors++;
      test_done;
    end
  endtask
  initial begin
    repeat (6) @(negedge core_clk);
    rst_n = 1'b1;
    @(negedge core_clk);
    chk("idle_pins", {6'h00, cmd_ready, rom_ce_n, rom_oe_n, rom_width_sel, rom_vpp_en, rom_vcc_hi,
        identify_hv_en, rom_q_oe, top_oe, rsp_valid}, 16'h03C0);
    clk_en    = 1'b0;
    cmd_valid = 1'b1;
    repeat (5) @(negedge core_clk);
    chk("frozen", {14'h0000, cmd_ready, rom_ce_n}, 16'h0003);
    cmd_valid = 1'b0;
    clk_en    = 1'b1;
    for (int i = 0; i < 8; i++) shadow[i] = 16'hFFFF;
    for (int i = 0; i < 4; i++) begin
      run(otp_host_pkg::OP_READ_WORD, 20'($random(seed)) & 20'h00007, 16'($random(seed)));
      chk("blank", rsp_data, 16'hFFFF);
    end
    for (int i = 0; i < 3; i++) begin
      id_flip = (i == 2);
      run(otp_host_pkg::OP_IDENTIFY, 20'(i & 1), 16'h0000);
      d = ((i & 1) ? DEV_ID : MFR_ID) ^ {15'h0000, id_flip};
      chk("ident", rsp_data, d);
      chk("ident_par", {15'h0000, rsp_fail}, {15'h0000, ~^d});
    end
    id_flip = 1'b0;
    for (int i = 0; i < 6; i++) begin
      need = (i < 2) ? 5'h01 : (i < 4) ? 5'h03 : 5'h1F;
      d = (i == 0) ? 16'h0000 : 16'($random(seed)) & 16'h7FFF;
      if (i < 4) shadow[i] = d;
      run(otp_host_pkg::OP_PROGRAM, 20'(i), d);
      chk("pgm_fail", {15'h0000, rsp_fail}, {15'h0000, i >= 4});
      chk("pgm_pulses", {11'h000, rsp_pulses}, (i < 4) ? {11'h000, need} : 16'h0019);
    end
    need = 5'h01;
    run(otp_host_pkg::OP_PROGRAM, 20'h00000, 16'hFFFF);
    chk("no_set", {10'h000, rsp_fail, rsp_pulses}, 16'h0039);
    for (int i = 0; i < 8; i++) begin
      run(otp_host_pkg::OP_FINAL_VERIFY, 20'(i), shadow[i] ^ {15'h0000, i == 7});
      chk("final", {15'h0000, rsp_fail}, {15'h0000, i == 7});
      run(otp_host_pkg::OP_READ_WORD, 20'(i), 16'h0000);
      chk("word", rsp_data, shadow[i]);
      for (int b = 0; b < 2; b++) begin
        run(otp_host_pkg::OP_READ_BYTE, 20'(2 * i + b), 16'h0000);
        chk("byte", rsp_data, byte_of(shadow[i], b[0]));
      end
    end
    test_done;
  end
endmodule // otp_rom_mode_control_test
`default_nettype wire
